// file: rtl/cfre_consts.svh
// Constants of the processor flag word and reset entry block.
`ifndef CFRE_CONSTS_SVH
`define CFRE_CONSTS_SVH

// Register byte offsets on the AHB-Lite bus.
`define CFRE_OFS_FLAG 8'h00
`define CFRE_OFS_MODE0 8'h04
`define CFRE_OFS_STATUS 8'h08
`define CFRE_OFS_VECTOR 8'h0C

// Flag word field positions.
`define CFRE_BIT_CARRY 0
`define CFRE_BIT_DEBUG 1
`define CFRE_BIT_ZERO 2
`define CFRE_BIT_SIGN 3
`define CFRE_BIT_BANK 4
`define CFRE_BIT_OVF 5
`define CFRE_BIT_IEN 6
`define CFRE_BIT_STACK 7
`define CFRE_IPL_LO 12
`define CFRE_IPL_HI 14

// Writable bits of the flag word; bits 8 to 11 and 15 stay zero.
`define CFRE_FLAG_WMASK 16'h70FF
`define CFRE_FLAG_RST 16'h0000

// Mode register 0 software reset bit.
`define CFRE_BIT_SWRST 3

// Highest trap number that forces the handler stack.
`define CFRE_TRAP_STACK_MAX 6'h1F

// Reset pin low time in clock cycles; the software reset hold lasts one cycle more than its count.
`define CFRE_PIN_LOW_CYCLES 5'h14
`define CFRE_SWRST_CYCLES 5'h14

`endif

// file: rtl/cfre_pkg.sv
// Types shared by the flag word and reset entry block.
package cfre_pkg;

    // Reset entry sequencer states.
    typedef enum logic [1:0] {
        CFRE_ST_RUN = 2'b00,
        CFRE_ST_HOLD = 2'b01,
        CFRE_ST_FETCH = 2'b10
    } cfre_state_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [15:0] flags;
        cfre_state_t fsm;
        logic [4:0] sw_cnt;
        logic sw_cause;
        logic [19:0] fetch_addr;
        logic fetch_start;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic [31:0] pu_oe;
        logic pu_en;
        logic [74:0] fl_oe;
        logic [15:0] seg;
        logic [3:0] com;
    } cfre_top_state_t;

    // Whole state of the reset pin filter.
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [4:0] cnt;
        logic held;
    } cfre_filt_state_t;

endpackage : cfre_pkg

// file: rtl/cfre_pin_filter.sv
// Reset pin synchroniser and low-time filter.
`timescale 1ns/1ps
`default_nettype none
`include "cfre_consts.svh"

module cfre_pin_filter
    import cfre_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin_b,
    output logic o_held_low
);

    cfre_filt_state_t st;
    cfre_filt_state_t next_st;

    // The pin passes two flops; only the second is looked at by the counter.
    always_comb
    begin
        next_st = st;
        next_st.sync1 = i_pin_b;
        next_st.sync2 = st.sync1;
        if (st.sync2)
        begin
            next_st.cnt = 5'h00;
            next_st.held = 1'b0;
        end
        else if (st.cnt != (`CFRE_PIN_LOW_CYCLES - 5'h01))
        begin
            next_st.cnt = st.cnt + 5'h01;
        end
        else
        begin
            next_st.held = 1'b1;
        end
    end

    // State register; the pin idles high.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '{sync1: 1'b1, sync2: 1'b1, cnt: 5'h00, held: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_held_low = st.held;

endmodule : cfre_pin_filter
`default_nettype wire

// file: rtl/cfre_top.sv
// Processor flag word, interrupt gating and reset entry with an AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cfre_consts.svh"

// Function
// - Overflow bit 5 follows the arithmetic overflow result on each update.
// - Bit 6 gates maskable interrupts: zero blocks, one allows.
// - Acknowledging an interrupt clears the interrupt gate bit.
// - Bit 7 picks handler stack when zero, task stack when one.
// - Hardware interrupt or trap number 0 to 31 clears the stack bit.
// - Bits 12 to 14 hold the three-bit priority threshold.
// - An interrupt is taken only above the priority threshold.
// - Bits 8 to 11 and 15 are reserved and read zero.
// - Reset pin held low at least 20 cycles enters reset.
// - Pin released high leaves reset and fetches from the reset vector.
// - Software and pin resets give the same post-reset state; the code leaves the status cause bit set after a software reset.
// - In reset, pulled-up group inputs with pull-ups, others floating inputs.
// - In reset, all segment and common outputs drive high.
// - Bits 0 to 4: carry, debug, zero, sign, bank select.
// - Writing one to mode register 0 bit 3 starts software reset.
module cfre_top
    import cfre_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_reset_pin_b,
    input wire logic [19:0] i_reset_vector,
    input wire logic i_alu_update,
    input wire logic i_alu_carry,
    input wire logic i_alu_zero,
    input wire logic i_alu_sign,
    input wire logic i_alu_overflow,
    input wire logic i_irq_req,
    input wire logic [2:0] i_irq_level,
    input wire logic i_irq_ack,
    input wire logic i_trap_exec,
    input wire logic [5:0] i_trap_num,
    input wire logic [31:0] i_pulled_up_oe,
    input wire logic [74:0] i_floating_oe,
    input wire logic [15:0] i_segment_drive,
    input wire logic [3:0] i_common_drive,
    output logic o_irq_accept,
    output logic o_stack_sel,
    output logic o_bank_sel,
    output logic o_single_step,
    output logic [15:0] o_processor_flag_word,
    output logic o_in_reset,
    output logic o_fetch_start,
    output logic [19:0] o_fetch_addr,
    output logic [31:0] o_pulled_up_port_group_oe,
    output logic o_pulled_up_port_group_pu,
    output logic [74:0] o_floating_port_group_oe,
    output logic [15:0] o_segment_drive_pins,
    output logic [3:0] o_common_drive_pins
);

    ////////////////////////////////////////////////////////////////////////////////

    // Reset release synchroniser and filtered reset pin.
    logic [1:0] rst_sync;
    logic rst_n;
    logic held_low;

    // Release of the system reset passes two flops.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    cfre_pin_filter u_pin_filter (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_pin_b(i_reset_pin_b),
        .o_held_low(held_low)
    );

    ////////////////////////////////////////////////////////////////////////////////

    cfre_top_state_t st;
    cfre_top_state_t next_st;
    logic addr_take;
    logic wr_flag;
    logic wr_swrst;
    logic running;
    logic trap_low;
    logic [31:0] rd_value;
    logic [15:0] merged;

    // Bus helpers: a word transfer is taken on an address phase with hready high.
    assign addr_take = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'b010);
    assign running = (st.fsm == CFRE_ST_RUN);
    assign wr_flag = st.dp_valid && st.dp_write && (st.dp_addr == `CFRE_OFS_FLAG) && running;
    assign wr_swrst = st.dp_valid && st.dp_write && (st.dp_addr == `CFRE_OFS_MODE0)
        && i_hwdata[`CFRE_BIT_SWRST];
    assign trap_low = i_trap_exec && (i_trap_num <= `CFRE_TRAP_STACK_MAX);

    // Read data for the register being addressed; unmapped words read zero.
    always_comb
    begin
        rd_value = 32'h0000_0000;
        unique case (i_haddr[7:0])
            `CFRE_OFS_FLAG: rd_value = {16'h0000, st.flags & `CFRE_FLAG_WMASK};
            `CFRE_OFS_STATUS: rd_value = {29'h0000_0000, o_irq_accept, st.sw_cause,
                st.fsm == CFRE_ST_HOLD};
            `CFRE_OFS_VECTOR: rd_value = {12'h000, st.fetch_addr};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // Flag word update: software write first, then arithmetic, then interrupt entry.
    always_comb
    begin
        merged = st.flags;
        if (wr_flag)
        begin
            merged = i_hwdata[15:0] & `CFRE_FLAG_WMASK;
        end
        if (i_alu_update && running)
        begin
            merged[`CFRE_BIT_CARRY] = i_alu_carry;
            merged[`CFRE_BIT_ZERO] = i_alu_zero;
            merged[`CFRE_BIT_SIGN] = i_alu_sign;
            merged[`CFRE_BIT_OVF] = i_alu_overflow;
        end
        if ((i_irq_ack || i_trap_exec) && running)
        begin
            merged[`CFRE_BIT_IEN] = 1'b0;
        end
        if ((i_irq_ack || trap_low) && running)
        begin
            merged[`CFRE_BIT_STACK] = 1'b0;
        end
    end

    // Next state: bus pipeline, reset sequencer and reset pin states.
    always_comb
    begin
        next_st = st;
        next_st.fetch_start = 1'b0;
        next_st.dp_valid = addr_take;
        next_st.dp_write = i_hwrite;
        next_st.dp_addr = i_haddr[7:0];
        if (addr_take && !i_hwrite)
        begin
            next_st.rdata = rd_value;
        end
        next_st.flags = merged;
        unique case (st.fsm)
            CFRE_ST_RUN:
            begin
                if (held_low)
                begin
                    next_st.fsm = CFRE_ST_HOLD;
                    next_st.sw_cause = 1'b0;
                end
                else if (wr_swrst)
                begin
                    next_st.fsm = CFRE_ST_HOLD;
                    next_st.sw_cause = 1'b1;
                    next_st.sw_cnt = 5'h00;
                end
            end
            CFRE_ST_HOLD:
            begin
                // Both reset kinds share this state, so the exit flag word is identical; sw_cause still tells them apart.
                next_st.flags = `CFRE_FLAG_RST;
                if (held_low)
                begin
                    next_st.sw_cause = 1'b0;
                end
                else if (st.sw_cause && (st.sw_cnt != `CFRE_SWRST_CYCLES))
                begin
                    next_st.sw_cnt = st.sw_cnt + 5'h01;
                end
                else
                begin
                    next_st.fsm = CFRE_ST_FETCH;
                    next_st.fetch_start = 1'b1;
                    next_st.fetch_addr = i_reset_vector;
                end
            end
            CFRE_ST_FETCH:
            begin
                next_st.fsm = CFRE_ST_RUN;
            end
            default:
            begin
                next_st.fsm = CFRE_ST_HOLD;
            end
        endcase
        // Pin states follow the coming state so they line up with the reset state.
        if (next_st.fsm == CFRE_ST_HOLD)
        begin
            next_st.pu_oe = 32'h0000_0000;
            next_st.pu_en = 1'b1;
            next_st.fl_oe = 75'h0;
            next_st.seg = 16'hFFFF;
            next_st.com = 4'hF;
        end
        else
        begin
            next_st.pu_oe = i_pulled_up_oe;
            next_st.pu_en = 1'b0;
            next_st.fl_oe = i_floating_oe;
            next_st.seg = i_segment_drive;
            next_st.com = i_common_drive;
        end
    end

    // State register; power-up enters the reset state with pins in their reset mode.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{flags: `CFRE_FLAG_RST, fsm: CFRE_ST_HOLD, sw_cnt: 5'h00,
                sw_cause: 1'b0, fetch_addr: 20'h0_0000, fetch_start: 1'b0,
                dp_valid: 1'b0, dp_write: 1'b0, dp_addr: 8'h00,
                rdata: 32'h0000_0000, pu_oe: 32'h0000_0000, pu_en: 1'b1,
                fl_oe: 75'h0, seg: 16'hFFFF, com: 4'hF};
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Interrupt acceptance and flag outputs.
    assign o_irq_accept = i_irq_req && running && st.flags[`CFRE_BIT_IEN]
        && (i_irq_level > st.flags[`CFRE_IPL_HI:`CFRE_IPL_LO]);
    assign o_stack_sel = st.flags[`CFRE_BIT_STACK];
    assign o_bank_sel = st.flags[`CFRE_BIT_BANK];
    assign o_single_step = st.flags[`CFRE_BIT_DEBUG];
    assign o_processor_flag_word = st.flags;

    // Bus answers in zero wait states and always OKAY.
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = st.rdata;

    // Reset entry and pin outputs.
    assign o_in_reset = (st.fsm == CFRE_ST_HOLD);
    assign o_fetch_start = st.fetch_start;
    assign o_fetch_addr = st.fetch_addr;
    assign o_pulled_up_port_group_oe = st.pu_oe;
    assign o_pulled_up_port_group_pu = st.pu_en;
    assign o_floating_port_group_oe = st.fl_oe;
    assign o_segment_drive_pins = st.seg;
    assign o_common_drive_pins = st.com;

    ////////////////////////////////////////////////////////////////////////////////

    // Overflow bit tracks an arithmetic update when no write collides.
    a_ovf_tracks: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_alu_update && running && !wr_flag) |=> (st.flags[5] == $past(i_alu_overflow)))
        else $error("overflow bit did not follow the arithmetic result");

    // A cleared gate bit never lets an interrupt through.
    a_gate_blocks: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        !st.flags[6] |-> !o_irq_accept)
        else $error("interrupt accepted with gate bit clear");

    // Acknowledge clears the gate bit on the next edge.
    a_ack_clears_ien: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_irq_ack && running) |=> !st.flags[6])
        else $error("gate bit still set after acknowledge");

    // Hardware interrupt or low trap forces the handler stack.
    a_stack_forced: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        ((i_irq_ack || (i_trap_exec && i_trap_num < 6'd32)) && running) |=> !o_stack_sel)
        else $error("stack select not cleared on interrupt entry");

    // A written threshold lands in bits 12 to 14.
    a_ipl_written: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        wr_flag |=> (st.flags[14:12] == $past(i_hwdata[14:12])))
        else $error("priority threshold not stored");

    // Accepted requests are strictly above the threshold.
    a_ipl_strict: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        o_irq_accept |-> (i_irq_level > o_processor_flag_word[14:12]))
        else $error("interrupt accepted at or below threshold");

    // Reserved bits stay zero.
    a_rsvd_zero: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (st.flags[11:8] == 4'h0) && !st.flags[15])
        else $error("reserved flag bits not zero");

    // A filtered low pin puts a running device into reset.
    a_pin_enters: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (held_low && running) |=> o_in_reset)
        else $error("reset pin low time did not enter reset");

    // The fetch pulse carries the vector sampled on leaving reset.
    a_vec_fetch: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        $fell(o_in_reset) |-> (o_fetch_start && o_fetch_addr == $past(i_reset_vector)))
        else $error("reset exit did not fetch the reset vector");

    // Every reset exit shows the same flag word.
    a_same_exit: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        o_fetch_start |-> (st.flags == 16'h0000))
        else $error("post-reset flag word differs");

    // Port groups are inputs, pulled-up group with pull-ups, in reset.
    a_ports_reset: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        o_in_reset |-> (o_pulled_up_port_group_pu && o_pulled_up_port_group_oe == 32'h0
            && o_floating_port_group_oe == 75'h0))
        else $error("port groups not inputs during reset");

    // Display lines drive high in reset.
    a_display_high: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        o_in_reset |-> (&o_segment_drive_pins && &o_common_drive_pins))
        else $error("display outputs not high during reset");

    // Software reset holds the device in reset for at least eight cycles.
    a_sw_reset: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (wr_swrst && running && !held_low) |=> o_in_reset [*8])
        else $error("software reset did not hold the device");

endmodule : cfre_top
`default_nettype wire

// file: bench/cfre_reset_source.sv
// Behavioural model of the external circuit that drives the reset pin.
`timescale 1ns/1ps
`default_nettype none

module cfre_reset_source
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_low_cycles,
    output wire logic o_reset_pin_b
);
    logic [7:0] low_left = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // A request loads the low time, never shorter than twenty cycles, then counts it down.
    always @(posedge i_clk)
    begin
        if (i_go)
            low_left <= (i_low_cycles < 8'h14) ? 8'h14 : i_low_cycles;
        else if (low_left != 8'h00)
            low_left <= low_left - 8'h01;
    end

    // The pin sits at its pulled-up level whenever the source is not pulling it low.
    assign o_reset_pin_b = (low_left == 8'h00);
endmodule : cfre_reset_source
`default_nettype wire

// file: bench/cfre_top_test.sv
// Self-checking testbench of the flag word and reset entry block.
`timescale 1ns/1ps
`default_nettype none
`include "cfre_consts.svh"

module cfre_top_test;
    import cfre_pkg::*;
    logic i_clk, i_rst_b, i_hsel, i_hwrite, i_alu_update, i_alu_carry, i_alu_zero, go;
    logic i_alu_sign, i_alu_overflow, i_irq_req, i_irq_ack, i_trap_exec, reset_pin_b;
    logic [31:0] i_haddr, i_hwdata, i_pulled_up_oe, hrd, o_hrdata, o_pulled_up_port_group_oe;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize, i_irq_level;
    logic [19:0] i_reset_vector, o_fetch_addr;
    logic [5:0] i_trap_num;
    logic [74:0] i_floating_oe, o_floating_port_group_oe;
    logic [15:0] i_segment_drive, o_processor_flag_word, o_segment_drive_pins;
    logic [3:0] i_common_drive, o_common_drive_pins;
    logic [7:0] low_cycles;
    logic o_hreadyout, o_hresp, o_irq_accept, o_stack_sel, o_bank_sel, o_single_step;
    logic o_in_reset, o_fetch_start, o_pulled_up_port_group_pu;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    cfre_top dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_hrdata(o_hrdata), .i_reset_pin_b(reset_pin_b), .i_reset_vector(i_reset_vector),
        .i_alu_update(i_alu_update), .i_alu_carry(i_alu_carry), .i_alu_zero(i_alu_zero),
        .i_alu_sign(i_alu_sign), .i_alu_overflow(i_alu_overflow), .i_irq_req(i_irq_req),
        .i_irq_level(i_irq_level), .i_irq_ack(i_irq_ack), .i_trap_exec(i_trap_exec),
        .i_trap_num(i_trap_num), .i_pulled_up_oe(i_pulled_up_oe),
        .i_floating_oe(i_floating_oe), .i_segment_drive(i_segment_drive),
        .i_common_drive(i_common_drive), .o_irq_accept(o_irq_accept),
        .o_stack_sel(o_stack_sel), .o_bank_sel(o_bank_sel), .o_single_step(o_single_step),
        .o_processor_flag_word(o_processor_flag_word), .o_in_reset(o_in_reset),
        .o_fetch_start(o_fetch_start), .o_fetch_addr(o_fetch_addr),
        .o_pulled_up_port_group_oe(o_pulled_up_port_group_oe),
        .o_pulled_up_port_group_pu(o_pulled_up_port_group_pu),
        .o_floating_port_group_oe(o_floating_port_group_oe),
        .o_segment_drive_pins(o_segment_drive_pins), .o_common_drive_pins(o_common_drive_pins)
    );

    cfre_reset_source source (
        .i_clk(i_clk), .i_go(go), .i_low_cycles(low_cycles), .o_reset_pin_b(reset_pin_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // The clock runs at 100 MHz.
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // A hung wait is cut short well after the whole sequence should have ended.
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Compares one value and reports a difference at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Waits for the edge at which the slave shows ready.
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge i_clk);
        while (o_hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask : wait_ready

    // One single word transfer; read data is taken at the edge that ends the data phase.
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr <= {24'h00_0000, addr};
        i_hwrite <= wr;
        i_hsize <= 3'b010;
        wait_ready();
        i_htrans <= 2'b00;
        i_hwdata <= wdata;
        wait_ready();
        hrd = o_hrdata;
        chk("hresp okay", 32'h0, {31'h0, o_hresp});
        i_hsel <= 1'b0;
    endtask : bus

    // Polls after each edge until the reset flag reaches a level, counting the edges.
    task automatic wait_reset(input logic lvl, output int n);
        n = 0;
        while (o_in_reset !== lvl && n < 200)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask : wait_reset

    // Checks the pin states that hold while the device sits in reset.
    task automatic chk_reset_pins;
        chk("segment pins", 32'h0000_FFFF, {16'h0000, o_segment_drive_pins});
        chk("common pins", 32'h0000_000F, {28'h000_0000, o_common_drive_pins});
        chk("pull up on", 32'h0000_0001, {31'h0, o_pulled_up_port_group_pu});
        chk("pulled group oe", 32'h0000_0000, o_pulled_up_port_group_oe);
        chk("floating group oe", 32'h0, {31'h0, |o_floating_port_group_oe});
    endtask : chk_reset_pins

    // Waits for the restart pulse, checks its address, then the state once running.
    task automatic chk_restart(input logic [19:0] vec, input logic sw);
        int n;
        n = 0;
        while (o_fetch_start !== 1'b1 && n < 200)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("fetch pulse", 32'h1, {31'h0, o_fetch_start});
        chk("fetch address", {12'h000, vec}, {12'h000, o_fetch_addr});
        wait_reset(1'b0, n);
        bus(1'b0, `CFRE_OFS_FLAG, 32'h0);
        chk("flags after reset", 32'h0, {16'h0000, hrd[15:0]});
        bus(1'b0, `CFRE_OFS_STATUS, 32'h0);
        chk("software cause", {31'h0, sw}, {31'h0, hrd[1]});
        bus(1'b0, `CFRE_OFS_VECTOR, 32'h0);
        chk("vector register", {12'h000, vec}, hrd);
    endtask : chk_restart

    ////////////////////////////////////////////////////////////////////////////////
    // Reserved bits stay zero; the stack, bank and debug bits reach their outputs.
    task automatic t_flags;
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_FFFF);
        bus(1'b0, `CFRE_OFS_FLAG, 32'h0);
        chk("flag word", 32'h0000_70FF, {16'h0000, hrd[15:0]});
        chk("stack select", 32'h1, {31'h0, o_stack_sel});
        chk("bank select", 32'h1, {31'h0, o_bank_sel});
        chk("single step", 32'h1, {31'h0, o_single_step});
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_0000);
        #1;
        chk("stack cleared", 32'h0, {31'h0, o_stack_sel});
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped read", 32'h0, hrd);
    endtask : t_flags

    // Each arithmetic flag is loaded alone, then all are cleared.
    task automatic t_alu;
        logic [3:0] v;
        for (int i = 0; i < 5; i++)
        begin
            v = (i < 4) ? (4'h1 << i) : 4'h0;
            @(posedge i_clk);
            {i_alu_overflow, i_alu_sign, i_alu_zero, i_alu_carry} <= v;
            i_alu_update <= 1'b1;
            @(posedge i_clk);
            i_alu_update <= 1'b0;
            #1;
            chk("alu flags", {26'h0, v[3], 1'b0, v[2], v[1], 1'b0, v[0]},
                {26'h0, o_processor_flag_word[5:0] & 6'h2D});
        end
    endtask : t_alu

    // Requests at every level against threshold 3, level 7 against threshold 7, with the gate open and shut.
    task automatic t_irq;
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_3040);
        for (int l = 0; l < 8; l++)
        begin
            @(posedge i_clk);
            i_irq_req <= 1'b1;
            i_irq_level <= l[2:0];
            #1;
            chk("accept over 3", {31'h0, l > 3}, {31'h0, o_irq_accept});
        end
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_7040);
        #1;
        chk("accept at 7", 32'h0, {31'h0, o_irq_accept});
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_0000);
        #1;
        chk("gate shut", 32'h0, {31'h0, o_irq_accept});
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_0040);
        #1;
        chk("gate open", 32'h1, {31'h0, o_irq_accept});
        i_irq_req <= 1'b0;
    endtask : t_irq

    // Acknowledge and traps 0, 31 and 32 against a word with gate and stack bits set.
    task automatic t_ack_trap;
        logic [5:0] nums [4] = '{6'h00, 6'h00, 6'h1F, 6'h20};
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_00C0);
            @(posedge i_clk);
            i_irq_ack <= (i == 0);
            i_trap_exec <= (i != 0);
            i_trap_num <= nums[i];
            @(posedge i_clk);
            i_irq_ack <= 1'b0;
            i_trap_exec <= 1'b0;
            #1;
            chk("gate and stack", {30'h0, i == 3, 1'b0},
                {30'h0, o_processor_flag_word[7:6]});
        end
    endtask : t_ack_trap

    // The source holds the pin low twenty cycles; the device enters reset and restarts.
    task automatic t_pin_reset;
        int n;
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_30FF);
        i_reset_vector <= 20'hA_5C3E;
        @(posedge i_clk);
        go <= 1'b1;
        low_cycles <= 8'h14;
        @(posedge i_clk);
        go <= 1'b0;
        wait_reset(1'b1, n);
        chk("in reset", 32'h1, {31'h0, o_in_reset});
        chk("not before low time", 32'h1, {31'h0, n >= 19});
        chk_reset_pins();
        chk_restart(20'hA_5C3E, 1'b0);
    endtask : t_pin_reset

    // A mode register write resets the device like the pin; the status cause bit then reads one.
    task automatic t_soft_reset;
        int n;
        bus(1'b1, `CFRE_OFS_FLAG, 32'h0000_50D5);
        i_reset_vector <= 20'h3_1F0D;
        bus(1'b1, `CFRE_OFS_MODE0, 32'h0000_0008);
        wait_reset(1'b1, n);
        chk("soft in reset", 32'h1, {31'h0, o_in_reset});
        chk_reset_pins();
        chk_restart(20'h3_1F0D, 1'b1);
    endtask : t_soft_reset

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, pin states, then each scenario in turn.
    initial
    begin
        int n;
        {i_rst_b, i_hsel, i_hwrite, i_alu_update, i_alu_carry, i_alu_zero, go} = 7'h00;
        {i_alu_sign, i_alu_overflow, i_irq_req, i_irq_ack, i_trap_exec} = 5'h00;
        {i_haddr, i_hwdata, i_htrans, i_hsize, i_irq_level, i_trap_num} = '0;
        i_reset_vector = 20'h0_4321;
        i_pulled_up_oe = 32'hFFFF_FFFF;
        i_floating_oe = {75{1'b1}};
        i_segment_drive = 16'h0000;
        i_common_drive = 4'h0;
        low_cycles = 8'h00;
        repeat (8) @(posedge i_clk);
        #1;
        chk_reset_pins();
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        chk_restart(20'h0_4321, 1'b0);
        chk("run segment pins", 32'h0, {16'h0000, o_segment_drive_pins});
        t_flags();
        t_alu();
        t_irq();
        t_ack_trap();
        t_pin_reset();
        t_soft_reset();
        test_done();
    end
endmodule : cfre_top_test
`default_nettype wire
